// file: rtl/ptb_map.vh
`ifndef PTB_MAP_VH
`define PTB_MAP_VH

// Decoded base of the control registers
`define PTB_REG_BASE      32'h41006000
// Arbitrary default for where the trace SRAM appears in the memory map
`define PTB_SRAM_BASE     32'h20000000

// Register byte offsets
`define PTB_OFF_POSITION  4'h0
`define PTB_OFF_MASTER    4'h4
`define PTB_OFF_FLOW      4'h8
`define PTB_OFF_BASE      4'hC

// Field positions
`define PTB_POS_WRAP      2
`define PTB_PTR_LSB       3
`define PTB_MST_EN        31
`define PTB_MST_MASK_MSB  4
`define PTB_MST_MASK_LSB  0
`define PTB_FLOW_STOP     0
`define PTB_FLOW_HALT     1
`define PTB_PKT_FLAG      0
// Address bits below this pick a register inside the block
`define PTB_DEC_LSB       4

// Reset values
`define PTB_MASK_RST      5'h00
`define PTB_RDATA_RST     32'h00000000

`endif

// file: rtl/ptb_trace_buffer.v
// Function
// R01: Capture reported flow changes while tracing active
// R02: Two-word packet per non-sequential PC change
// R03: Trace SRAM writes beat processor accesses
// R04: Record only while enable bit is one
// R05: Auto stop when pointer reaches watermark
// R06: Without watermark, pointer wraps and overwrites
// R07: Registers decoded at fixed base, fixed offsets
// R08: Four registers; position holds pointer, wrap
// R09: Flow register: watermark, stop and halt bits
// R10: Base register reports trace SRAM location
// R11: Trace region position and size programmable
// R12: Debugger reads SRAM, rebuilds program flow
// R13: Halt request when pointer reaches watermark
// R14: Wrap flag sticky until software clears
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "ptb_map.vh"

module ptb_trace_buffer #(
  parameter        AW        = 13,
  parameter [31:0] SRAM_BASE = `PTB_SRAM_BASE
) (
  input  wire          clk,
  input  wire          nrst,
  input  wire [31:0]   reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  input  wire          trc_valid,
  input  wire [31:0]   trc_src,
  input  wire [31:0]   trc_dst,
  input  wire          trc_excp,
  input  wire          trc_start,
  input  wire          trc_stop,
  input  wire          cpu_req,
  input  wire          cpu_we,
  input  wire [AW-1:0] cpu_addr,
  input  wire [31:0]   cpu_wdata,
  output wire          cpu_ready,
  output reg  [31:0]   cpu_rdata,
  output wire          halt_req,
  output wire          trace_active
);

  localparam PW    = AW - 1;
  localparam DEPTH = 1 << AW;
  localparam [31:0] REG_BASE = `PTB_REG_BASE;
  // Zero fill around each read-back field
  localparam POS_PAD = 32 - PW - `PTB_PTR_LSB;
  localparam MST_PAD = `PTB_MST_EN - `PTB_MST_MASK_MSB - 1;
  localparam FLW_PAD = 32 - PW - `PTB_PTR_LSB;
  localparam FLW_GAP = `PTB_PTR_LSB - `PTB_FLOW_HALT - 1;

  // Two write cycles per packet; only idle frees the SRAM port
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_W0   = 2'b01;
  localparam [1:0] ST_W1   = 2'b10;

  reg  [31:0]   mem_r [0:DEPTH-1];
  reg  [1:0]    st_r;
  reg  [1:0]    st_nxt;
  reg  [PW-1:0] ptr_r;
  reg  [PW-1:0] wm_r;
  reg  [4:0]    mask_r;
  reg           en_r;
  reg           wrap_r;
  reg           stop_en_r;
  reg           halt_en_r;
  reg           halt_r;
  reg           start_r;
  reg  [31:0]   pk_w0_r;
  reg  [31:0]   pk_w1_r;
  reg  [31:0]   rd_nxt;
  reg           en_nxt;

  wire [PW-1:0] rm;
  wire [PW-1:0] ptr_inc;
  wire [PW-1:0] ptr_nxt;
  wire          adv;
  wire          wrap_hit;
  wire          wm_hit;
  wire          stop_hit;
  wire          take;
  wire          wr_pos;
  wire          wr_mst;
  wire          wr_flow;
  // Register decode
  wire          sel_pos;
  wire          sel_mst;
  wire          sel_flow;
  wire          sel_base;
  wire          en_rise;

  // Region mask in packet units: region holds 2^(mask+1) packets
  // A mask wider than the pointer simply covers the whole array
  function [PW-1:0] ptb_region_mask;
    input [4:0] mk;
    integer i;
    begin
      for (i = 0; i < PW; i = i + 1) begin
        ptb_region_mask[i] = (i <= mk);
      end
    end
  endfunction

  // R07: fixed base and offset
  function ptb_sel;
    input [31:0] a;
    input [`PTB_DEC_LSB-1:0] off;
    begin
      ptb_sel = (a[31:`PTB_DEC_LSB] == REG_BASE[31:`PTB_DEC_LSB]) && (a[`PTB_DEC_LSB-1:0] == off);
    end
  endfunction

  // R07: each register decoded once; base feeds the read path only, the others both paths
  assign sel_pos  = ptb_sel(reg_addr, `PTB_OFF_POSITION);
  assign sel_mst  = ptb_sel(reg_addr, `PTB_OFF_MASTER);
  assign sel_flow = ptb_sel(reg_addr, `PTB_OFF_FLOW);
  assign sel_base = ptb_sel(reg_addr, `PTB_OFF_BASE);
  assign wr_pos   = reg_wr && sel_pos;
  assign wr_mst   = reg_wr && sel_mst;
  assign wr_flow  = reg_wr && sel_flow;

  // R11: upper pointer bits fix the region, masked bits roll inside it
  assign rm       = ptb_region_mask(mask_r);
  assign ptr_inc  = ptr_r + {{(PW-1){1'b0}}, 1'b1};
  assign ptr_nxt  = (ptr_r & ~rm) | (ptr_inc & rm);
  assign adv      = (st_r == ST_W1);
  // R06: wrap back to region start
  assign wrap_hit = adv && ((ptr_r & rm) == rm);
  // Compares the pointer a packet leaves behind, so a stop never splits a packet
  assign wm_hit   = adv && (ptr_nxt == wm_r);
  // R05: watermark stop
  assign stop_hit = wm_hit && stop_en_r;

  // R01: capture while active; a packet landing on the stop point is not taken
  // R04: enable gates capture
  assign take = trc_valid && en_r && (st_r != ST_W0) && !stop_hit;

  // R03: processor waits while a trace word goes to SRAM
  // Combinational so the stall is seen in the very cycle the port is claimed
  assign cpu_ready    = (st_r == ST_IDLE);
  assign halt_req     = halt_r;
  assign trace_active = en_r;

  always @* begin
    case (st_r)
      ST_IDLE: st_nxt = take ? ST_W0 : ST_IDLE;
      ST_W0:   st_nxt = ST_W1;
      ST_W1:   st_nxt = take ? ST_W0 : ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r    <= ST_IDLE;
      pk_w0_r <= `PTB_RDATA_RST;
      pk_w1_r <= `PTB_RDATA_RST;
    end else begin
      st_r <= st_nxt;
      // R02: two words, source with exception flag, target with start flag
      if (take) begin
        pk_w0_r <= {trc_src[31:1], trc_excp};
        pk_w1_r <= {trc_dst[31:1], start_r};
      end
    end
  end

  // First packet after a start is marked so the debugger can split runs
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_r <= 1'b0;
    end else if (en_rise) begin
      start_r <= 1'b1;
    end else if (take) begin
      start_r <= 1'b0;
    end
  end

  // R04: direct enable write, then stop pin or watermark, then start pin
  always @* begin
    en_nxt = en_r;
    if (wr_mst) begin
      en_nxt = reg_wdata[`PTB_MST_EN];
    end else if (trc_stop || stop_hit) begin
      en_nxt = 1'b0;
    end else if (trc_start) begin
      en_nxt = 1'b1;
    end
  end

  // Only a real rise marks a run, so a start beaten by a stop marks nothing
  assign en_rise = en_nxt && !en_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_r <= `PTB_MASK_RST;
    end else if (wr_mst) begin
      mask_r <= reg_wdata[`PTB_MST_MASK_MSB:`PTB_MST_MASK_LSB];
    end
  end

  // R09: watermark and two control bits
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wm_r      <= {PW{1'b0}};
      stop_en_r <= 1'b0;
      halt_en_r <= 1'b0;
    end else if (wr_flow) begin
      wm_r      <= reg_wdata[PW+`PTB_PTR_LSB-1:`PTB_PTR_LSB];
      stop_en_r <= reg_wdata[`PTB_FLOW_STOP];
      halt_en_r <= reg_wdata[`PTB_FLOW_HALT];
    end
  end

  // Software pointer write wins over a trace advance in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_r <= {PW{1'b0}};
    end else if (wr_pos) begin
      ptr_r <= reg_wdata[PW+`PTB_PTR_LSB-1:`PTB_PTR_LSB];
    end else if (adv) begin
      ptr_r <= ptr_nxt;
    end
  end

  // R14: sticky wrap flag, a new wrap beats a clearing write
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrap_r <= 1'b0;
    end else if (wrap_hit) begin
      wrap_r <= 1'b1;
    end else if (wr_pos) begin
      wrap_r <= reg_wdata[`PTB_POS_WRAP];
    end
  end

  // R13: halt request held until the master register is written
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      halt_r <= 1'b0;
    end else if (wm_hit && halt_en_r) begin
      halt_r <= 1'b1;
    end else if (wr_mst) begin
      halt_r <= 1'b0;
    end
  end

  // No reset on the array: it is plain SRAM shared with the processor
  // R03: trace words own the write port; R12: debugger reads the same array
  always @(posedge clk) begin
    if (st_r == ST_W0) begin
      mem_r[{ptr_r, 1'b0}] <= pk_w0_r;
    end else if (st_r == ST_W1) begin
      mem_r[{ptr_r, 1'b1}] <= pk_w1_r;
    end else if (cpu_req && cpu_we) begin
      mem_r[cpu_addr] <= cpu_wdata;
    end
  end

  // A stalled read is taken later; the requester keeps its request up meanwhile
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_rdata <= `PTB_RDATA_RST;
    end else if (cpu_req && !cpu_we && cpu_ready) begin
      cpu_rdata <= mem_r[cpu_addr];
    end
  end

  // R08: four registers; R10: base reports SRAM location
  always @* begin
    rd_nxt = `PTB_RDATA_RST;
    if (sel_pos) begin
      rd_nxt = {{POS_PAD{1'b0}}, ptr_r, wrap_r, {`PTB_POS_WRAP{1'b0}}};
    end else if (sel_mst) begin
      rd_nxt = {en_r, {MST_PAD{1'b0}}, mask_r};
    end else if (sel_flow) begin
      rd_nxt = {{FLW_PAD{1'b0}}, wm_r, {FLW_GAP{1'b0}}, halt_en_r, stop_en_r};
    end else if (sel_base) begin
      rd_nxt = SRAM_BASE;
    end
  end

  // Read data hold until the next read, so a late sample still sees them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `PTB_RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end
  end

endmodule // ptb_trace_buffer

// file: test/ptb_trace_buffer_properties.sv
`timescale 1ns/1ps
module ptb_trace_buffer_properties #(parameter [31:0] SRAM_BASE = 32'h20000000) (
  input wire clk, input wire nrst, input wire [31:0] reg_addr, input wire [31:0] reg_wdata,
  input wire reg_wr, input wire reg_rd, input wire [31:0] reg_rdata, input wire trc_valid,
  input wire trc_stop, input wire trc_start, input wire cpu_ready, input wire halt_req, input wire trace_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wire mst_wr = reg_wr && reg_addr == 32'h41006004;
  wire wr_en  = reg_wdata[31];
  // Trace write holds the SRAM for both words
  sequence s_busy2; !cpu_ready ##1 !cpu_ready; endsequence
  two_word_a: assert property (trc_valid && trace_active && cpu_ready |=> s_busy2)
    else $error("trace write length");
  idle_off_a: assert property (!trace_active && cpu_ready |=> cpu_ready)
    else $error("write while stopped");
  halt_cause_a: assert property ($rose(halt_req) |-> !$past(cpu_ready))
    else $error("halt without packet");
  halt_clear_a: assert property (mst_wr && cpu_ready |=> !halt_req)
    else $error("halt not cleared");
  en_write_a: assert property (mst_wr |=> trace_active == $past(wr_en))
    else $error("enable write lost");
  stop_pin_a: assert property (trc_stop && !reg_wr |=> !trace_active)
    else $error("stop ignored");
  start_pin_a: assert property (trc_start && !trc_stop && !reg_wr && cpu_ready |=> trace_active)
    else $error("start ignored");
  base_read_a: assert property (reg_rd && reg_addr == 32'h4100600C |=> reg_rdata == SRAM_BASE)
    else $error("base wrong");
  unmapped_a: assert property (reg_rd && reg_addr[31:4] != 28'h4100600 |=> reg_rdata == 32'h0)
    else $error("unmapped read");
endmodule // ptb_trace_buffer_properties
bind ptb_trace_buffer ptb_trace_buffer_properties #(.SRAM_BASE(SRAM_BASE)) u_props (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trc_valid(trc_valid), .trc_stop(trc_stop), .trc_start(trc_start),
  .cpu_ready(cpu_ready), .halt_req(halt_req), .trace_active(trace_active));

// file: test/ptb_cpu_model.sv
`timescale 1ns/1ps
module ptb_cpu_model (
  input wire clk, input wire nrst, input wire go, input wire we, input wire [12:0] addr,
  input wire [31:0] wdata, input wire cpu_ready, output reg cpu_req, output reg cpu_we,
  output reg [12:0] cpu_addr, output reg [31:0] cpu_wdata
);
  // request held until taken, released lines inverted so stale values never match
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_req <= 1'b0; cpu_we <= 1'b0; cpu_addr <= 13'h0; cpu_wdata <= 32'h0;
    end else if (cpu_req && cpu_ready) begin
      cpu_req <= 1'b0; cpu_addr <= ~cpu_addr; cpu_wdata <= ~cpu_wdata;
    end else if (go) begin
      cpu_req <= 1'b1; cpu_we <= we; cpu_addr <= addr; cpu_wdata <= wdata;
    end
  end
endmodule // ptb_cpu_model

// file: test/tb_ptb_trace_buffer.sv
`timescale 1ns/1ps
`include "ptb_map.vh"
module tb_ptb_trace_buffer;
  reg clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, trc_valid = 0, trc_excp = 0, trc_stop = 0;
  reg go = 0, we = 0, rr = 0, cr = 0, trc_start = 0, st;
  reg [31:0] reg_addr = 0, reg_wdata = 0, trc_src = 0, trc_dst = 0, wd = 0, seed = 32'h961B7ED0;
  reg [12:0] ad = 0;
  reg [31:0] q[$], em[0:7];
  wire [31:0] reg_rdata, cpu_rdata, cpu_wdata;
  wire [12:0] cpu_addr;
  wire cpu_req, cpu_we, cpu_ready, halt_req, trace_active;
  integer bad_count = 0, cmp_count = 0, i, j, p;
  initial forever #10 clk = ~clk;
  ptb_trace_buffer u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trc_valid(trc_valid),
    .trc_src(trc_src), .trc_dst(trc_dst), .trc_excp(trc_excp), .trc_start(trc_start),
    .trc_stop(trc_stop), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_rdata(cpu_rdata),
    .halt_req(halt_req), .trace_active(trace_active));
  ptb_cpu_model u_cpu (.clk(clk), .nrst(nrst), .go(go), .we(we), .addr(ad), .wdata(wd),
    .cpu_ready(cpu_ready), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata));
  task end_of_test; begin
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end endtask
  task eq(input [31:0] v, input [31:0] e); begin
    cmp_count = cmp_count + 1;
    if (v !== e) begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, v, e);
    end
  end endtask
  // Results land one cycle after the taken read; oldest note first
  always @(posedge clk) begin
    if (rr || cr) eq(rr ? reg_rdata : cpu_rdata, q.size() ? q.pop_front() : 32'hDEADBEEF);
    rr <= reg_rd;
    cr <= cpu_req && !cpu_we && cpu_ready;
  end
  task wr(input [3:0] o, input [31:0] d); begin
    reg_addr <= `PTB_REG_BASE + o; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk); reg_wr <= 1'b0; @(posedge clk);
  end endtask
  task rd(input [31:0] a, input [31:0] e); begin
    q.push_back(e); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk); reg_rd <= 1'b0; @(posedge clk);
  end endtask
  task pk(input en); begin
    trc_src <= $random(seed); trc_dst <= $random(seed); trc_excp <= $random(seed); trc_valid <= 1'b1;
    @(posedge clk); trc_valid <= 1'b0;
    if (en) begin
      em[2*p] = {trc_src[31:1], trc_excp}; em[2*p+1] = {trc_dst[31:1], st}; st = 0; p = (p + 1) % 4;
    end
    @(posedge clk);
  end endtask
  task ca(input w, input [12:0] a, input [31:0] d); begin
    if (!w) q.push_back(d);
    we <= w; ad <= a; wd <= d; go <= 1'b1;
    @(posedge clk); go <= 1'b0;
    for (i = 0; i < 20; i = i + 1) begin @(negedge clk); if (!cpu_req) i = 99; end
    if (i == 20) begin bad_count = bad_count + 1; end_of_test; end
    @(posedge clk);
  end endtask
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(`PTB_REG_BASE + `PTB_OFF_BASE, `PTB_SRAM_BASE);
    rd(32'h41006010, 32'h0);
    rd(`PTB_REG_BASE, 32'h0);
    p = 0; st = 1;
    // Region of four packets so the fifth one wraps onto the first
    wr(`PTB_OFF_MASTER, 32'h80000001);
    rd(`PTB_REG_BASE + `PTB_OFF_MASTER, 32'h80000001);
    for (j = 0; j < 5; j = j + 1) pk(1'b1);
    fork pk(1'b1); ca(1'b1, 13'd20, 32'hA5A5A5A5); join
    rd(`PTB_REG_BASE, 32'h14);
    for (j = 0; j < 8; j = j + 1) ca(1'b0, j, em[j]);
    ca(1'b0, 13'd20, 32'hA5A5A5A5);
    wr(`PTB_OFF_POSITION, 32'h0);
    rd(`PTB_REG_BASE, 32'h0);
    wr(`PTB_OFF_FLOW, 32'h13);
    rd(`PTB_REG_BASE + `PTB_OFF_FLOW, 32'h13);
    pk(1'b1); pk(1'b1); pk(1'b0); #1;
    eq(trace_active, 32'h0);
    eq(halt_req, 32'h1);
    @(posedge clk); rd(`PTB_REG_BASE, 32'h10);
    wr(`PTB_OFF_MASTER, 32'h1); pk(1'b0); #1;
    eq(halt_req, 32'h0);
    @(posedge clk); rd(`PTB_REG_BASE, 32'h10);
    wr(`PTB_OFF_MASTER, 32'h80000001);
    trc_stop <= 1'b1; @(posedge clk); trc_stop <= 1'b0; @(posedge clk); #1;
    eq(trace_active, 32'h0);
    @(posedge clk); trc_start <= 1'b1; @(posedge clk); trc_start <= 1'b0; @(posedge clk); #1;
    eq(trace_active, 32'h1);
    repeat (3) @(posedge clk);
    end_of_test;
  end
endmodule // tb_ptb_trace_buffer
